// [hdl/extended_write_lock.sv]
// Extended write lock: judges each host write against sixteen lock bits.
// Assumes a bus front end presents one decoded command per cycle and
// gives the standard write-protect verdict on wpBlock.
`timescale 1ns/1ps
`default_nettype none
`include "ext_lock_consts.svh"
// Functional notes
// RULE1 - Lock register at code DD, word access
// RULE2 - Bit 15 reads zero, ignores writes
// RULE3 - Protect lock freezes both protect commands, sticky
// RULE4 - Trim lock blocks trim related commands
// RULE5 - Output command lock blocks mode and setpoint
// RULE6 - Bit 11 blocks output fault configuration
// RULE7 - Warning lock blocks warnings and alert mask
// RULE8 - Bit 9 blocks current, temperature faults
// RULE9 - Margin lock blocks margins and transition rate
// RULE10 - Operation lock blocks operation command
// RULE11 - Configuration lock blocks frequency, config, address
// RULE12 - Bit 5 blocks input overvoltage fault limit
// RULE13 - Sequence lock blocks sequencing commands
// RULE14 - Bit 3 blocks maker identity commands
// RULE15 - Passkey lock blocks passkey and unlocking
// RULE16 - Restore lock blocks host restore only
// RULE17 - Store lock acts after reset or restore
// RULE18 - Set store bit locks store and restore
// RULE19 - Either mechanism blocking rejects the write
// RULE20 - Loaded from nonvolatile memory, writes immediate
// RULE21 - Rejected writes change nothing, get flagged
module extended_write_lock #(
  parameter logic [7:0] BOOT_OFFSET_CMD = 8'hd0, // Device-specific code
  parameter logic [7:0] SYS_CFG_CMD = 8'hd1, // Device-specific code
  parameter logic [7:0] BUS_ADDR_CMD = 8'hd2, // Device-specific code
  parameter logic [7:0] COMP_CMD = 8'hd3 // Device-specific code
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic nvmLoad,
  input wire logic [15:0] nvmData,
  input wire logic cmdValid,
  input wire logic cmdWrite,
  input wire logic [7:0] cmdCode,
  input wire logic [15:0] cmdData,
  input wire logic wpBlock,
  input wire logic clrReject,
  output logic cmdAccept,
  output logic cmdReject,
  output logic rdValid,
  output logic [15:0] rdData,
  output logic rejectFlag,
  output logic [15:0] lockMask,
  output logic storeLockActive,
  output logic passkeyUnlockBlock
);
  lock_ctrl_if ctrl(); // Carrier to decoder and holder

  ext_lock_pkg::access_e access; // Kind of access this cycle
  logic isLockCmd; // Command addresses the lock register
  logic isStoreOrRestore; // Command is a store or a restore
  logic groupBlock; // Some set lock bit covers the command
  logic storeBlock; // Store or restore refused by store lock
  logic blocked; // Final verdict for a write
  logic rdValid_r; // Read answer strobe
  logic rdValid_nxt;
  ext_lock_pkg::lock_mask_t rdData_r; // Read answer word
  ext_lock_pkg::lock_mask_t rdData_nxt;
  logic rejectFlag_r; // Sticky rejected-write flag
  logic rejectFlag_nxt;

  // Group lookup for the presented command
  cmd_group_decode #(
    .BOOT_OFFSET_CMD(BOOT_OFFSET_CMD),
    .SYS_CFG_CMD(SYS_CFG_CMD),
    .BUS_ADDR_CMD(BUS_ADDR_CMD),
    .COMP_CMD(COMP_CMD)
  ) u_decode (
    .bus(ctrl.decoder)
  );

  // Live lock bits and captured store lock
  lock_holder u_holder (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .bus(ctrl.holder)
  );

  // Classify the access
  always_comb
  begin
    if (!cmdValid)
      access = ext_lock_pkg::ACC_NONE;
    else if (cmdWrite)
      access = ext_lock_pkg::ACC_WRITE;
    else
      access = ext_lock_pkg::ACC_READ;
  end

  // Decode helpers
  assign isLockCmd = (cmdCode == `CMD_LOCK_MASK); // [RULE1]
  assign isStoreOrRestore = (cmdCode == `CMD_STORE_ALL) || (cmdCode == `CMD_RESTORE_ALL);

  // Group blocking; protect bit also covers the lock register itself
  assign groupBlock = |(ctrl.groupHit & ctrl.mask); // [RULE4] [RULE3]

  // Store lock: captured value gates store, live bit gates both at once
  assign storeBlock = ((cmdCode == `CMD_STORE_ALL) && ctrl.storeLockEff) // [RULE17]
    || (isStoreOrRestore && ctrl.mask[`BIT_STORE]); // [RULE18]

  // Either mechanism is enough to refuse
  assign blocked = wpBlock || groupBlock || storeBlock; // [RULE19]

  // Write verdict handshakes
  assign cmdAccept = (access == ext_lock_pkg::ACC_WRITE) && !blocked;
  assign cmdReject = (access == ext_lock_pkg::ACC_WRITE) && blocked; // [RULE21]

  // Drive the holder: only an accepted write reaches it
  assign ctrl.code = cmdCode;
  assign ctrl.loadEn = nvmLoad; // [RULE20] [RULE16]
  assign ctrl.loadVal = nvmData;
  assign ctrl.wrEn = cmdAccept && isLockCmd; // [RULE21]
  assign ctrl.wrVal = cmdData;

  // Read answer and reject flag next values
  always_comb
  begin
    rdValid_nxt = (access == ext_lock_pkg::ACC_READ) && isLockCmd; // [RULE1]
    rdData_nxt = rdData_r;
    if (rdValid_nxt)
    begin
      // Unused top bit always reads zero
      rdData_nxt = ctrl.mask;
      rdData_nxt[`BIT_UNUSED] = 1'b0; // [RULE2]
    end
    // A new rejection wins over a clear in the same cycle
    if (cmdReject)
      rejectFlag_nxt = 1'b1; // [RULE21]
    else if (clrReject)
      rejectFlag_nxt = 1'b0;
    else
      rejectFlag_nxt = rejectFlag_r;
  end

  // Register stage for the read path and the flag
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdValid_r <= 1'b0;
      rdData_r <= `LOCK_RESET_VAL;
      rejectFlag_r <= 1'b0;
    end
    else
    begin
      rdValid_r <= rdValid_nxt;
      rdData_r <= rdData_nxt;
      rejectFlag_r <= rejectFlag_nxt;
    end
  end

  // Outputs
  assign rdValid = rdValid_r;
  assign rdData = rdData_r;
  assign rejectFlag = rejectFlag_r;
  assign lockMask = ctrl.mask;
  assign storeLockActive = ctrl.storeLockEff;
  // Passkey unlocking is refused while the passkey lock is set
  assign passkeyUnlockBlock = ctrl.mask[`BIT_PASSKEY]; // [RULE15]

  // Checks on the lock behaviour
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  // Accepted lock write, no load alongside
  sequence s_lock_write;
    cmdAccept && isLockCmd && !nvmLoad;
  endsequence

  // Refused lock write, no load alongside
  sequence s_lock_refused;
    cmdReject && isLockCmd && !nvmLoad;
  endsequence

  property p_lock_write;
    s_lock_write |=> lockMask[13:0] == $past(cmdData[13:0]);
  endproperty
  a_lock_write: assert property (p_lock_write) // [RULE1]
    else $error("Accepted lock write not applied");

  property p_read_back;
    (cmdValid && !cmdWrite && isLockCmd) |=> rdValid && rdData == {1'b0, $past(lockMask[14:0])};
  endproperty
  a_read_back: assert property (p_read_back) // [RULE1]
    else $error("Lock read answer wrong");

  property p_unused_zero;
    !lockMask[15] && !rdData[15];
  endproperty
  a_unused_zero: assert property (p_unused_zero) // [RULE2]
    else $error("Unused bit not zero");

  property p_protect_sticky;
    (lockMask[14] && !nvmLoad) |=> lockMask[14];
  endproperty
  a_protect_sticky: assert property (p_protect_sticky) // [RULE3]
    else $error("Protect lock cleared by write");

  property p_group_block;
    (cmdValid && cmdWrite && |(ctrl.groupHit & lockMask)) |-> cmdReject && !cmdAccept;
  endproperty
  a_group_block: assert property (p_group_block) // [RULE4]
    else $error("Locked group write accepted");

  property p_std_protect;
    (cmdValid && cmdWrite && wpBlock) |-> cmdReject;
  endproperty
  a_std_protect: assert property (p_std_protect) // [RULE19]
    else $error("Write-protected command accepted");

  property p_store_now;
    (cmdValid && cmdWrite && lockMask[0] && isStoreOrRestore) |-> cmdReject;
  endproperty
  a_store_now: assert property (p_store_now) // [RULE18]
    else $error("Store or restore passed with store lock set");

  property p_store_deferred;
    $changed(storeLockActive) |-> $past(nvmLoad) && storeLockActive == $past(nvmData[0]);
  endproperty
  a_store_deferred: assert property (p_store_deferred) // [RULE17]
    else $error("Store lock changed outside a load");

  property p_refused_stable;
    s_lock_refused |=> $stable(lockMask) && rejectFlag;
  endproperty
  a_refused_stable: assert property (p_refused_stable) // [RULE21]
    else $error("Refused write altered lock bits");

  property p_reject_flag;
    cmdReject |=> rejectFlag;
  endproperty
  a_reject_flag: assert property (p_reject_flag) // [RULE21]
    else $error("Rejected write not flagged");

  property p_nvm_load;
    nvmLoad |=> lockMask == {1'b0, $past(nvmData[14:0])};
  endproperty
  a_nvm_load: assert property (p_nvm_load) // [RULE20]
    else $error("Nonvolatile load not applied");

  property p_flag_clear;
    (clrReject && !cmdReject) |=> !rejectFlag;
  endproperty
  a_flag_clear: assert property (p_flag_clear) // [RULE21]
    else $error("Reject flag not cleared");

  property p_flag_hold;
    (!clrReject && !cmdReject) |=> rejectFlag == $past(rejectFlag);
  endproperty
  a_flag_hold: assert property (p_flag_hold) // [RULE21]
    else $error("Reject flag changed without cause");

  property p_rd_quiet;
    !(cmdValid && !cmdWrite && isLockCmd) |=> !rdValid;
  endproperty
  a_rd_quiet: assert property (p_rd_quiet) // [RULE1]
    else $error("Read answer without a lock read");

  property p_rd_hold;
    !(cmdValid && !cmdWrite && isLockCmd) |=> $stable(rdData);
  endproperty
  a_rd_hold: assert property (p_rd_hold) // [RULE1]
    else $error("Read word changed without a lock read");

  property p_store_live;
    s_lock_write |=> $stable(storeLockActive);
  endproperty
  a_store_live: assert property (p_store_live) // [RULE17]
    else $error("Store lock took effect on a live write");

  property p_restore_lock;
    (cmdValid && cmdWrite && lockMask[`BIT_RESTORE] && cmdCode == `CMD_RESTORE_ALL)
      |-> cmdReject;
  endproperty
  a_restore_lock: assert property (p_restore_lock) // [RULE16]
    else $error("Host restore passed with restore lock set");

  property p_store_captured;
    (cmdValid && cmdWrite && storeLockActive && cmdCode == `CMD_STORE_ALL) |-> cmdReject;
  endproperty
  a_store_captured: assert property (p_store_captured) // [RULE17]
    else $error("Store passed with captured store lock");

  property p_protect_cmds;
    (cmdValid && cmdWrite && lockMask[`BIT_PROTECT]
      && (isLockCmd || cmdCode == `CMD_WRITE_PROTECT)) |-> cmdReject;
  endproperty
  a_protect_cmds: assert property (p_protect_cmds) // [RULE3]
    else $error("Protect command written under protect lock");

  property p_open_accept;
    (cmdValid && cmdWrite && lockMask == 16'h0000 && !wpBlock && !storeLockActive)
      |-> cmdAccept;
  endproperty
  a_open_accept: assert property (p_open_accept) // [RULE19]
    else $error("Unlocked write refused");
endmodule
`default_nettype wire

// [hdl/ext_lock_consts.svh]
// Command codes, lock bit positions and reset values for the extended lock.
// Assumes it is included by its bare name from the design sources.
`ifndef EXT_LOCK_CONSTS_SVH
`define EXT_LOCK_CONSTS_SVH
// Command codes that the lock logic inspects
`define CMD_OPERATION 8'h01
`define CMD_ON_OFF_CONFIG 8'h02
`define CMD_PASSKEY 8'h0e
`define CMD_WRITE_PROTECT 8'h10
`define CMD_STORE_ALL 8'h15
`define CMD_RESTORE_ALL 8'h16
`define CMD_ALERT_MASK 8'h1b
`define CMD_VOUT_MODE 8'h20
`define CMD_VOUT_COMMAND 8'h21
`define CMD_VOUT_TRIM 8'h22
`define CMD_VOUT_MAX 8'h24
`define CMD_MARGIN_HIGH 8'h25
`define CMD_MARGIN_LOW 8'h26
`define CMD_TRANSITION_RATE 8'h27
`define CMD_SCALE_LOOP 8'h29
`define CMD_SCALE_MONITOR 8'h2a
`define CMD_VOUT_MIN 8'h2b
`define CMD_FREQ_SWITCH 8'h33
`define CMD_VIN_ON 8'h35
`define CMD_VIN_OFF 8'h36
`define CMD_MFR_ID 8'h99
`define CMD_MFR_MODEL 8'h9a
`define CMD_MFR_REVISION 8'h9b
`define CMD_LOCK_MASK 8'hdd
`define CMD_CURRENT_MONITOR_CALIBRATION 8'hde
// Fault, warning and sequencing commands covered by lock groups
`define CMD_VOUT_OV_FLT 8'h40
`define CMD_VOUT_OV_RSP 8'h41
`define CMD_VOUT_OV_WRN 8'h42
`define CMD_VOUT_UV_WRN 8'h43
`define CMD_VOUT_UV_FLT 8'h44
`define CMD_VOUT_UV_RSP 8'h45
`define CMD_IOUT_OC_FLT 8'h46
`define CMD_IOUT_OC_RSP 8'h47
`define CMD_IOUT_OC_WRN 8'h4a
`define CMD_OT_FLT 8'h4f
`define CMD_OT_RSP 8'h50
`define CMD_OT_WRN 8'h51
`define CMD_VIN_OV_FLT 8'h55
`define CMD_TON_DELAY 8'h60
`define CMD_TON_RISE 8'h61
`define CMD_TOFF_DELAY 8'h64
`define CMD_TOFF_FALL 8'h65
// Lock bit positions
`define BIT_UNUSED 15
`define BIT_PROTECT 14
`define BIT_TRIM 13
`define BIT_OUT_CMD 12
`define BIT_OUT_FAULT 11
`define BIT_WARNING 10
`define BIT_CUR_TEMP 9
`define BIT_MARGIN 8
`define BIT_OPERATION 7
`define BIT_CONFIG 6
`define BIT_IN_FAULT 5
`define BIT_SEQUENCE 4
`define BIT_MAKER 3
`define BIT_PASSKEY 2
`define BIT_RESTORE 1
`define BIT_STORE 0
// Value held until the nonvolatile load arrives
`define LOCK_RESET_VAL 16'h0000
`endif

// [hdl/ext_lock_pkg.sv]
// Types shared by the extended write lock modules.
// Assumes nothing beyond a SystemVerilog compiler.
package ext_lock_pkg;
  // Sixteen lock bits, one per command group except unused bit 15
  typedef logic [15:0] lock_mask_t;
  // Management bus command code
  typedef logic [7:0] cmd_code_t;
  // Kind of access seen in the current cycle
  typedef enum {ACC_NONE, ACC_READ, ACC_WRITE} access_e;
endpackage

// [hdl/lock_ctrl_if.sv]
// Carrier between the lock core, its group decoder and its lock holder.
// Assumes all three parts sit on one clock.
`timescale 1ns/1ps
`default_nettype none
interface lock_ctrl_if;
  ext_lock_pkg::cmd_code_t code; // Command under test
  ext_lock_pkg::lock_mask_t groupHit; // Groups the command belongs to
  logic loadEn; // Nonvolatile load or restore pulse
  ext_lock_pkg::lock_mask_t loadVal; // Value from nonvolatile memory
  logic wrEn; // Accepted host write to the lock register
  ext_lock_pkg::lock_mask_t wrVal; // Data of that write
  ext_lock_pkg::lock_mask_t mask; // Live lock bits
  logic storeLockEff; // Store lock as captured at load
  modport decoder (input code, output groupHit);
  modport holder (input loadEn, loadVal, wrEn, wrVal, output mask, storeLockEff);
  modport core (output code, loadEn, loadVal, wrEn, wrVal,
    input groupHit, mask, storeLockEff);
endinterface
`default_nettype wire

// [hdl/cmd_group_decode.sv]
// Maps a command code onto the lock groups that cover it.
// Assumes codes of device-specific commands are given as parameters.
`timescale 1ns/1ps
`default_nettype none
`include "ext_lock_consts.svh"
module cmd_group_decode #(
  parameter logic [7:0] BOOT_OFFSET_CMD = 8'hd0, // boot_voltage_offset
  parameter logic [7:0] SYS_CFG_CMD = 8'hd1, // system_configuration
  parameter logic [7:0] BUS_ADDR_CMD = 8'hd2, // bus_address_setting
  parameter logic [7:0] COMP_CMD = 8'hd3 // Loop compensation
) (
  lock_ctrl_if.decoder bus
);
  // One-hot over lock bits; a code may hit one group only
  function automatic ext_lock_pkg::lock_mask_t groups(input logic [7:0] c);
    ext_lock_pkg::lock_mask_t g;
    g = '0;
    if (c == `CMD_WRITE_PROTECT || c == `CMD_LOCK_MASK)
      g[`BIT_PROTECT] = 1'b1; // [RULE3]
    else if (c == `CMD_VOUT_TRIM || c == `CMD_CURRENT_MONITOR_CALIBRATION || c == `CMD_SCALE_LOOP
             || c == `CMD_SCALE_MONITOR || c == BOOT_OFFSET_CMD)
      g[`BIT_TRIM] = 1'b1; // [RULE4]
    else if (c == `CMD_VOUT_MODE || c == `CMD_VOUT_COMMAND)
      g[`BIT_OUT_CMD] = 1'b1; // [RULE5]
    else if (c == `CMD_VOUT_MAX || c == `CMD_VOUT_MIN || c == `CMD_VOUT_OV_FLT
             || c == `CMD_VOUT_OV_RSP || c == `CMD_VOUT_UV_FLT || c == `CMD_VOUT_UV_RSP)
      g[`BIT_OUT_FAULT] = 1'b1; // [RULE6]
    else if (c == `CMD_ALERT_MASK || c == `CMD_VOUT_OV_WRN || c == `CMD_VOUT_UV_WRN
             || c == `CMD_IOUT_OC_WRN || c == `CMD_OT_WRN)
      g[`BIT_WARNING] = 1'b1; // [RULE7]
    else if (c == `CMD_IOUT_OC_FLT || c == `CMD_IOUT_OC_RSP || c == `CMD_OT_FLT
             || c == `CMD_OT_RSP)
      g[`BIT_CUR_TEMP] = 1'b1; // [RULE8]
    else if (c == `CMD_MARGIN_HIGH || c == `CMD_MARGIN_LOW || c == `CMD_TRANSITION_RATE)
      g[`BIT_MARGIN] = 1'b1; // [RULE9]
    else if (c == `CMD_OPERATION)
      g[`BIT_OPERATION] = 1'b1; // [RULE10]
    else if (c == `CMD_FREQ_SWITCH || c == SYS_CFG_CMD || c == BUS_ADDR_CMD
             || c == COMP_CMD)
      g[`BIT_CONFIG] = 1'b1; // [RULE11]
    else if (c == `CMD_VIN_OV_FLT)
      g[`BIT_IN_FAULT] = 1'b1; // [RULE12]
    else if (c == `CMD_TON_DELAY || c == `CMD_TON_RISE || c == `CMD_TOFF_DELAY
             || c == `CMD_TOFF_FALL
             || c == `CMD_ON_OFF_CONFIG || c == `CMD_VIN_ON || c == `CMD_VIN_OFF)
      g[`BIT_SEQUENCE] = 1'b1; // [RULE13]
    else if (c == `CMD_MFR_ID || c == `CMD_MFR_MODEL || c == `CMD_MFR_REVISION)
      g[`BIT_MAKER] = 1'b1; // [RULE14]
    else if (c == `CMD_PASSKEY)
      g[`BIT_PASSKEY] = 1'b1; // [RULE15]
    else if (c == `CMD_RESTORE_ALL)
      g[`BIT_RESTORE] = 1'b1; // [RULE16]
    else if (c == `CMD_STORE_ALL)
      g[`BIT_STORE] = 1'b1; // [RULE17]
    return g;
  endfunction

  // Purely combinational lookup
  assign bus.groupHit = groups(bus.code);
endmodule
`default_nettype wire

// [hdl/lock_holder.sv]
// Holds the live lock bits and the store lock captured at load time.
// Assumes the core only raises wrEn for accepted writes.
`timescale 1ns/1ps
`default_nettype none
`include "ext_lock_consts.svh"
module lock_holder (
  input wire logic ref_clk,
  input wire logic rst_n,
  lock_ctrl_if.holder bus
);
  ext_lock_pkg::lock_mask_t mask_r; // Live lock bits
  ext_lock_pkg::lock_mask_t mask_nxt;
  logic storeEff_r; // Store lock in force for store commands
  logic storeEff_nxt;

  // Next value: nonvolatile load wins over a host write
  always_comb
  begin
    mask_nxt = mask_r;
    storeEff_nxt = storeEff_r;
    if (bus.loadEn)
    begin
      // Power-up or restore: store lock takes effect now
      mask_nxt = bus.loadVal; // [RULE20]
      storeEff_nxt = bus.loadVal[`BIT_STORE]; // [RULE17]
    end
    else if (bus.wrEn)
    begin
      // Host write applies at once, protect bit cannot fall
      mask_nxt = bus.wrVal; // [RULE20]
      mask_nxt[`BIT_PROTECT] = bus.wrVal[`BIT_PROTECT] | mask_r[`BIT_PROTECT]; // [RULE3]
    end
    mask_nxt[`BIT_UNUSED] = 1'b0; // [RULE2]
  end

  // Register stage
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mask_r <= `LOCK_RESET_VAL;
      storeEff_r <= 1'b0;
    end
    else
    begin
      mask_r <= mask_nxt;
      storeEff_r <= storeEff_nxt;
    end
  end

  assign bus.mask = mask_r;
  assign bus.storeLockEff = storeEff_r;
endmodule
`default_nettype wire

// [verification/pmbus_host_model.sv]
// Host side model: presents one management bus command per cycle.
// Assumes the bench calls its tasks and the device answers combinationally.
`timescale 1ns/1ps
`default_nettype none
module pmbus_host_model (
  input wire logic ref_clk,
  output logic cmdValid,
  output logic cmdWrite,
  output logic [7:0] cmdCode,
  output logic [15:0] cmdData,
  output logic wpBlock
);
  // Idle bus at time zero
  initial
  begin
    cmdValid = 1'b0;
    cmdWrite = 1'b0;
    cmdCode = 8'h00;
    cmdData = 16'h0000;
    wpBlock = 1'b0;
  end

  // Present a command at a rising edge, one per cycle
  task automatic issue(input logic wr, input logic [7:0] code, input logic [15:0] data,
    input logic wp);
    @(posedge ref_clk);
    cmdValid <= 1'b1;
    cmdWrite <= wr;
    cmdCode <= code;
    cmdData <= data;
    wpBlock <= wp;
  endtask

  // Release the bus; data lines flip so stale words never look valid
  task automatic idle();
    @(posedge ref_clk);
    cmdValid <= 1'b0;
    cmdWrite <= 1'b0;
    wpBlock <= 1'b0;
    cmdData <= ~cmdData;
  endtask
endmodule
`default_nettype wire

// [verification/test_extended_write_lock.sv]
// Self-checking bench for the extended write lock, with a reference model.
// Assumes the host model drives commands and the bench drives the NVM load.
`timescale 1ns/1ps
`default_nettype none
`include "ext_lock_consts.svh"
`define CHK(nm, e, g) begin check_count++; if ((e) !== (g)) begin miscompares++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module test_extended_write_lock;
  logic ref_clk, rst_n, nvmLoad, clrReject; // Bench driven controls
  logic [15:0] nvmData; // Word offered by NVM
  logic cmdValid, cmdWrite, wpBlock; // From host model
  logic [7:0] cmdCode; // From host model
  logic [15:0] cmdData, rdData, lockMask; // Data paths
  logic cmdAccept, cmdReject, rdValid, rejectFlag, storeLockActive, passkeyUnlockBlock;
  logic [15:0] mdl; // Reference lock word
  logic mdlSla, mdlFlag; // Reference captured store lock and flag
  int miscompares, check_count, seed, i;
  logic [7:0] codes [] = '{8'h22, 8'hde, 8'h29, 8'h2a, 8'hd0, 8'h20, 8'h21, 8'h24,
    8'h2b, 8'h1b, 8'h25, 8'h26, 8'h27, 8'h01, 8'h33, 8'hd1, 8'hd2, 8'hd3, 8'h02,
    8'h35, 8'h36, 8'h99, 8'h9a, 8'h9b, 8'h0e, 8'h16, 8'h15, 8'h10, 8'hdd,
    8'h40, 8'h41, 8'h44, 8'h45, 8'h42, 8'h43, 8'h4a, 8'h51, 8'h46, 8'h47, 8'h4f,
    8'h50, 8'h55, 8'h60, 8'h61, 8'h64, 8'h65};

  // Free running 125 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  pmbus_host_model host (.ref_clk(ref_clk), .cmdValid(cmdValid), .cmdWrite(cmdWrite),
    .cmdCode(cmdCode), .cmdData(cmdData), .wpBlock(wpBlock));

  extended_write_lock DUT (.ref_clk(ref_clk), .rst_n(rst_n), .nvmLoad(nvmLoad),
    .nvmData(nvmData), .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdCode(cmdCode),
    .cmdData(cmdData), .wpBlock(wpBlock), .clrReject(clrReject), .cmdAccept(cmdAccept),
    .cmdReject(cmdReject), .rdValid(rdValid), .rdData(rdData), .rejectFlag(rejectFlag),
    .lockMask(lockMask), .storeLockActive(storeLockActive),
    .passkeyUnlockBlock(passkeyUnlockBlock));

  // Lock bit guarding a command, or -1 when no lock bit covers it
  function automatic int grp(input logic [7:0] c);
    case (c)
      8'h22, 8'hde, 8'h29, 8'h2a, 8'hd0: return 13;
      8'h20, 8'h21: return 12;
      8'h24, 8'h2b, 8'h40, 8'h41, 8'h44, 8'h45: return 11;
      8'h1b, 8'h42, 8'h43, 8'h4a, 8'h51: return 10;
      8'h46, 8'h47, 8'h4f, 8'h50: return 9;
      8'h25, 8'h26, 8'h27: return 8;
      8'h01: return 7;
      8'h33, 8'hd1, 8'hd2, 8'hd3: return 6;
      8'h55: return 5;
      8'h02, 8'h35, 8'h36, 8'h60, 8'h61, 8'h64, 8'h65: return 4;
      8'h99, 8'h9a, 8'h9b: return 3;
      8'h0e: return 2;
      8'h16: return 1;
      8'h15: return 0;
      8'h10, 8'hdd: return 14;
      default: return -1;
    endcase
  endfunction

  // Verdict and counts; the single place where the run ends
  task automatic stop_test();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // NVM load ignores every lock and captures the store lock
  task automatic load(input logic [15:0] v);
    @(posedge ref_clk);
    nvmLoad <= 1'b1;
    nvmData <= v;
    @(posedge ref_clk);
    nvmLoad <= 1'b0;
    nvmData <= ~v;
    mdl = v & 16'h7fff;
    mdlSla = v[0];
    @(negedge ref_clk);
    `CHK("lockMask", mdl, lockMask)
    `CHK("storeLockActive", mdlSla, storeLockActive)
  endtask

  // One command with the verdict predicted by the reference model
  task automatic op(input logic wr, input logic [7:0] code, input logic [15:0] data,
    input logic wp);
    int g;
    logic exRej;
    host.issue(wr, code, data, wp);
    @(negedge ref_clk);
    g = grp(code);
    exRej = wp || (g >= 0 && mdl[g]) || (code == 8'h15 && (mdlSla || mdl[0]))
      || (code == 8'h16 && mdl[0]);
    `CHK("cmdReject", wr && exRej, cmdReject)
    `CHK("cmdAccept", wr && !exRej, cmdAccept)
    host.idle();
    if (wr && exRej)
      mdlFlag = 1'b1;
    if (wr && !exRej && code == 8'hdd)
      mdl = (data & 16'h7fff) | (mdl & 16'h4000);
    @(negedge ref_clk);
    `CHK("lockMask", mdl, lockMask)
    `CHK("rejectFlag", mdlFlag, rejectFlag)
    `CHK("passkeyUnlockBlock", mdl[2], passkeyUnlockBlock)
    `CHK("storeLockActive", mdlSla, storeLockActive)
    `CHK("rdValid", (!wr && code == 8'hdd), rdValid)
    if (!wr && code == 8'hdd)
      `CHK("rdData", mdl, rdData)
  endtask

  // Hang guard
  initial
  begin
    repeat (50000) @(posedge ref_clk);
    miscompares++;
    stop_test();
  end

  // Main sequence
  initial
  begin
    seed = 32'hf058;
    rst_n = 1'b0;
    nvmLoad = 1'b0;
    nvmData = 16'h0000;
    clrReject = 1'b0;
    mdl = 16'h0000;
    mdlSla = 1'b0;
    mdlFlag = 1'b0;
    miscompares = 0;
    check_count = 0;
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(negedge ref_clk);
    `CHK("lockMask", 16'h0000, lockMask)
    load(16'h8000);
    // Bit 15 ignored, protect lock sticky against writes
    op(1'b1, 8'hdd, 16'hffff, 1'b0);
    op(1'b0, 8'hdd, 16'h0000, 1'b0);
    op(1'b1, 8'hdd, 16'h0000, 1'b0);
    op(1'b1, 8'h10, 16'h0000, 1'b0);
    // Standard write protect alone refuses
    load(16'h0000);
    op(1'b1, 8'h22, 16'h0000, 1'b1);
    // Every covered command with its own bit set, then the other bits among bits 1 to 13 set
    foreach (codes[k])
    begin
      load(16'h0001 << grp(codes[k]));
      op(1'b1, codes[k], 16'h0000, 1'b0);
      load(~(16'h0001 << grp(codes[k])) & 16'h3ffe);
      op(1'b1, codes[k], 16'h0000, 1'b0);
    end
    // Store lock set live blocks store and restore at once
    load(16'h0000);
    op(1'b1, 8'hdd, 16'h0001, 1'b0);
    op(1'b1, 8'h15, 16'h0000, 1'b0);
    op(1'b1, 8'h16, 16'h0000, 1'b0);
    // Store lock captured at load still blocks store after clearing
    load(16'h0001);
    op(1'b1, 8'hdd, 16'h0000, 1'b0);
    op(1'b1, 8'h15, 16'h0000, 1'b0);
    op(1'b1, 8'h16, 16'h0000, 1'b0);
    // Flag: a rejection beside a clear wins, a lone clear empties it
    host.issue(1'b1, 8'h15, 16'h0000, 1'b0);
    clrReject <= 1'b1;
    host.idle();
    mdlFlag = 1'b1;
    @(negedge ref_clk);
    `CHK("rejectFlag", mdlFlag, rejectFlag)
    @(posedge ref_clk);
    clrReject <= 1'b0;
    mdlFlag = 1'b0;
    @(negedge ref_clk);
    `CHK("rejectFlag", mdlFlag, rejectFlag)
    // Random traffic against the model
    for (i = 0; i < 60; i++)
    begin
      if (i % 4 == 0)
        load($random(seed));
      op($random(seed), codes[{$random(seed)} % codes.size()], $random(seed),
        ($random(seed) & 7) == 0);
    end
    stop_test();
  end
endmodule
`default_nettype wire
